// ===== core/lionc_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "lionc_map.vh"
// Functional notes
// - reserved ports are terminated internally; reads return all ones.
// - 2-byte windows 20h..3Ch every four go to master interrupt controller.
// - 2-byte windows A0h..BCh every four go to slave interrupt controller.
// - 2-byte window B2h goes to power management, always enabled.
// - 61h to NMI logic; 63h/65h/67h alias it only when enabled.
// - 71h-77h to RTC; 72/74/76 writes also NMI; 72h/73h disableable.
// - 84h(3), 88h(1), 8Ch(3) internal; writes also forwarded to LPC.
// - relocatable ranges use programmable bases anywhere in 64K space.
// - bit 7 set on system errors while bit 2 clear; 1-then-0 clears.
// - bit 6 set on I/O check while bit 3 clear; 1-then-0 clears.
// - bit 5 shows live counter 2 output.
// - bit 4 toggles at the refresh rate.
// - bits 3 and 2 mask their NMIs when one; reset to zero.
// - speaker low while bit 1 zero, else follows counter 2.
// - bit 0 gates counter 2 counting.
// - 70h write stores bit 7 NMI mask, bits 6:0 RTC index.
module lionc_decoder #(
   parameter REFRESH_CYC = `LIONC_REFRESH_CYC
) (
   input  wire        clock_in,
   input  wire        rstn_in,
   input  wire        io_valid_in,
   input  wire        io_write_in,
   input  wire [15:0] io_addr_in,
   input  wire [7:0]  io_wdata_in,
   input  wire [7:0]  tgt_rdata_in,
   input  wire        port_alias_enable_in,
   input  wire        rtc_hi_pair_enable_in,
   input  wire [15:0] acpi_base_in,
   input  wire [15:0] bmide_base_in,
   input  wire [15:0] smb_base_in,
   input  wire [15:0] gpio_base_in,
   input  wire [15:0] usb1_base_in,
   input  wire [15:0] usb2_base_in,
   input  wire [15:0] usb3_base_in,
   input  wire [6:0]  range_enable_in,
   input  wire        system_error_in,
   input  wire        io_check_error_in,
   input  wire        counter2_out_in,
   output reg         io_done_out,
   output reg  [7:0]  io_rdata_out,
   output reg  [3:0]  tgt_sel_out,
   output reg         tgt_valid_out,
   output reg         tgt_write_out,
   output reg  [15:0] tgt_addr_out,
   output reg  [7:0]  tgt_wdata_out,
   output reg         lpc_fwd_out,
   output reg         aborted_out,
   output reg         nmi_out,
   output reg         speaker_out,
   output reg         counter2_gate_out,
   output reg  [6:0]  rtc_index_out
);
   // ---------------------------------------------------------------
   // relocatable windows
   // ---------------------------------------------------------------
   wire [6:0] rhit;
   lionc_range_match #(.SZ(`LIONC_SZ_ACPI)) u_acpi (.addr_in(io_addr_in),
      .base_in(acpi_base_in), .enable_in(range_enable_in[0]), .hit_out(rhit[0]));
   lionc_range_match #(.SZ(`LIONC_SZ_BMIDE)) u_bmide (.addr_in(io_addr_in),
      .base_in(bmide_base_in), .enable_in(range_enable_in[1]), .hit_out(rhit[1]));
   lionc_range_match #(.SZ(`LIONC_SZ_SMB)) u_smb (.addr_in(io_addr_in),
      .base_in(smb_base_in), .enable_in(range_enable_in[2]), .hit_out(rhit[2]));
   lionc_range_match #(.SZ(`LIONC_SZ_GPIO)) u_gpio (.addr_in(io_addr_in),
      .base_in(gpio_base_in), .enable_in(range_enable_in[3]), .hit_out(rhit[3]));
   lionc_range_match #(.SZ(`LIONC_SZ_USB)) u_usb1 (.addr_in(io_addr_in),
      .base_in(usb1_base_in), .enable_in(range_enable_in[4]), .hit_out(rhit[4]));
   lionc_range_match #(.SZ(`LIONC_SZ_USB)) u_usb2 (.addr_in(io_addr_in),
      .base_in(usb2_base_in), .enable_in(range_enable_in[5]), .hit_out(rhit[5]));
   lionc_range_match #(.SZ(`LIONC_SZ_USB)) u_usb3 (.addr_in(io_addr_in),
      .base_in(usb3_base_in), .enable_in(range_enable_in[6]), .hit_out(rhit[6]));

   // ---------------------------------------------------------------
   // fixed decode
   // ---------------------------------------------------------------
   reg  [3:0] tsel;
   reg        fwd;
   wire [15:0] a = io_addr_in;
   wire        w = io_write_in;
   always @*
   begin
      tsel = `LIONC_T_NONE;
      fwd  = 1'b0;
      // fixed windows first; overlap with relocatable is undefined anyway
      if (a >= `LIONC_P_PIC1_LO && a <= `LIONC_P_PIC1_HI && a[1] == 1'b0)
         tsel = `LIONC_T_PIC1;
      else if (a == `LIONC_P_PM || a == `LIONC_P_PM + 16'h0001)
         tsel = `LIONC_T_PM;
      else if (a >= `LIONC_P_PIC2_LO && a <= `LIONC_P_PIC2_HI && a[1] == 1'b0)
         tsel = `LIONC_T_PIC2;
      else if ((a[15:2] == `LIONC_P_PIT0 >> 2) || (a[15:2] == `LIONC_P_PIT1 >> 2))
      begin
         if (a[1:0] != 2'b11 || w)
            tsel = `LIONC_T_PIT;
      end
      else if (a == `LIONC_P_STATUS)
         tsel = `LIONC_T_NMI;
      else if (a == 16'h0063 || a == 16'h0065 || a == 16'h0067)
      begin
         if (port_alias_enable_in)
            tsel = `LIONC_T_NMI;
      end
      else if (a == `LIONC_P_RTCIDX)
      begin
         if (w)
            tsel = `LIONC_T_NMI_RTC;
      end
      else if (a >= `LIONC_P_RTC_LO && a <= `LIONC_P_RTC_HI)
      begin
         if ((a == 16'h0072 || a == 16'h0073) && !rtc_hi_pair_enable_in)
            tsel = `LIONC_T_NONE;
         else if (w && a[0] == 1'b0)
            tsel = `LIONC_T_NMI_RTC;
         else
            tsel = `LIONC_T_RTC;
      end
      else if ((a >= `LIONC_P_INT84 && a <= `LIONC_P_INT84 + 16'h0002) ||
               a == `LIONC_P_INT88 ||
               (a >= `LIONC_P_INT8C && a <= `LIONC_P_INT8C + 16'h0002))
      begin
         tsel = `LIONC_T_INTERNAL;
         fwd  = w;
      end
      else if (a[15:3] == `LIONC_P_ATA0 >> 3 || a[15:3] == `LIONC_P_ATA1 >> 3 ||
               a == `LIONC_P_ATA2 || a == `LIONC_P_ATA3)
         tsel = `LIONC_T_ATA;
      else if (a[15:2] == `LIONC_P_CFGA >> 2 || a[15:2] == `LIONC_P_CFGD >> 2)
         tsel = `LIONC_T_CFG;
      else if (rhit[0])
         tsel = `LIONC_T_PM;
      else if (rhit[1])
         tsel = `LIONC_T_ATA;
      else if (rhit[2])
         tsel = `LIONC_T_SMB;
      else if (rhit[3])
         tsel = `LIONC_T_GPIO;
      else if (rhit[4])
         tsel = `LIONC_T_USB1;
      else if (rhit[5])
         tsel = `LIONC_T_USB2;
      else if (rhit[6])
         tsel = `LIONC_T_USB3;
   end

   // ---------------------------------------------------------------
   // status/control register and NMI
   // ---------------------------------------------------------------
   reg        serr_flag_q;
   reg        iocheck_flag_q;
   reg        iocheck_mask_q;
   reg        serr_mask_q;
   reg        speaker_gate_q;
   reg        refresh_q;
   reg [15:0] refresh_cnt_q;
   reg        nmi_global_mask_q;
   wire stat_wr = io_valid_in && w && tsel == `LIONC_T_NMI;
   wire idx_wr  = io_valid_in && w && a == `LIONC_P_RTCIDX;
   wire serr_mask_d    = stat_wr ? io_wdata_in[`LIONC_B_SERR_MASK] : serr_mask_q;
   wire iocheck_mask_d = stat_wr ? io_wdata_in[`LIONC_B_IOC_MASK] : iocheck_mask_q;
   // a set mask both blocks new events and clears the flag, so 1-then-0 re-arms
   wire serr_flag_d    = (system_error_in && !serr_mask_q) ||
                         (serr_flag_q && !serr_mask_q);
   wire iocheck_flag_d = (io_check_error_in && !iocheck_mask_q) ||
                         (iocheck_flag_q && !iocheck_mask_q);
   // bit 5 is the live counter input, unknown until the counter is programmed
   wire [7:0] stat_rd = {serr_flag_q, iocheck_flag_q, counter2_out_in, refresh_q,
                         iocheck_mask_q, serr_mask_q, speaker_gate_q,
                         counter2_gate_out};

   always @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         serr_flag_q       <= 1'b0;
         iocheck_flag_q    <= 1'b0;
         iocheck_mask_q    <= 1'b0;
         serr_mask_q       <= 1'b0;
         speaker_gate_q    <= 1'b0;
         counter2_gate_out <= 1'b0;
         refresh_q         <= 1'b0;
         refresh_cnt_q     <= 16'h0000;
         nmi_global_mask_q <= 1'b0;
         rtc_index_out     <= 7'h00;
         nmi_out           <= 1'b0;
         speaker_out       <= 1'b0;
         io_done_out       <= 1'b0;
         io_rdata_out      <= 8'h00;
         tgt_sel_out       <= `LIONC_T_NONE;
         tgt_valid_out     <= 1'b0;
         tgt_write_out     <= 1'b0;
         tgt_addr_out      <= 16'h0000;
         tgt_wdata_out     <= 8'h00;
         lpc_fwd_out       <= 1'b0;
         aborted_out       <= 1'b0;
      end
      else
      begin
         serr_flag_q  <= serr_flag_d;
         iocheck_flag_q <= iocheck_flag_d;
         serr_mask_q    <= serr_mask_d;
         iocheck_mask_q <= iocheck_mask_d;
         if (stat_wr)
         begin
            speaker_gate_q    <= io_wdata_in[`LIONC_B_SPK_GATE];
            counter2_gate_out <= io_wdata_in[`LIONC_B_C2_GATE];
         end
         if (idx_wr)
         begin
            nmi_global_mask_q <= io_wdata_in[`LIONC_B_NMI_GMASK];
            rtc_index_out     <= io_wdata_in[6:0];
         end
         // divided clock keeps the toggle free of any refresh engine
         if (refresh_cnt_q == REFRESH_CYC[15:0] - 16'h0001)
         begin
            refresh_cnt_q <= 16'h0000;
            refresh_q     <= ~refresh_q;
         end
         else
            refresh_cnt_q <= refresh_cnt_q + 16'h0001;
         nmi_out     <= (serr_flag_d || iocheck_flag_d) && !nmi_global_mask_q;
         speaker_out <= speaker_gate_q & counter2_out_in;
         // single-cycle cycle completion, answered one edge after the request
         io_done_out   <= io_valid_in;
         tgt_valid_out <= io_valid_in && tsel != `LIONC_T_NONE;
         tgt_sel_out   <= tsel;
         tgt_write_out <= w;
         tgt_addr_out  <= a;
         tgt_wdata_out <= io_wdata_in;
         lpc_fwd_out   <= io_valid_in && fwd;
         aborted_out   <= io_valid_in && tsel == `LIONC_T_NONE;
         if (!io_valid_in || w)
            io_rdata_out <= 8'h00;
         else if (tsel == `LIONC_T_NONE)
            io_rdata_out <= `LIONC_ALL_ONES;
         else if (tsel == `LIONC_T_NMI)
            io_rdata_out <= stat_rd;
         else
            io_rdata_out <= tgt_rdata_in;
      end
   end
endmodule // lionc_decoder
`default_nettype wire

// ===== core/lionc_map.vh
`ifndef LIONC_MAP_VH
`define LIONC_MAP_VH
// ---------------------------------------------------------------
// fixed ports
// ---------------------------------------------------------------
`define LIONC_P_STATUS     16'h0061
`define LIONC_P_RTCIDX     16'h0070
`define LIONC_P_PIC1_LO    16'h0020
`define LIONC_P_PIC1_HI    16'h003D
`define LIONC_P_PIC2_LO    16'h00A0
`define LIONC_P_PIC2_HI    16'h00BD
`define LIONC_P_PM         16'h00B2
`define LIONC_P_PIT0       16'h0040
`define LIONC_P_PIT1       16'h0050
`define LIONC_P_RTC_LO     16'h0071
`define LIONC_P_RTC_HI     16'h0077
`define LIONC_P_INT84      16'h0084
`define LIONC_P_INT88      16'h0088
`define LIONC_P_INT8C      16'h008C
`define LIONC_P_ATA0       16'h0170
`define LIONC_P_ATA1       16'h01F0
`define LIONC_P_ATA2       16'h0376
`define LIONC_P_ATA3       16'h03F6
`define LIONC_P_CFGA       16'h0CF8
`define LIONC_P_CFGD       16'h0CFC
// ---------------------------------------------------------------
// relocatable range sizes as address mask widths (log2 of bytes)
// ---------------------------------------------------------------
`define LIONC_SZ_ACPI      6
`define LIONC_SZ_BMIDE     4
`define LIONC_SZ_SMB       5
`define LIONC_SZ_GPIO      6
`define LIONC_SZ_USB       5
// ---------------------------------------------------------------
// status/control fields and reset
// ---------------------------------------------------------------
`define LIONC_B_SERR_FLAG  7
`define LIONC_B_IOC_FLAG   6
`define LIONC_B_C2OUT      5
`define LIONC_B_REFRESH    4
`define LIONC_B_IOC_MASK   3
`define LIONC_B_SERR_MASK  2
`define LIONC_B_SPK_GATE   1
`define LIONC_B_C2_GATE    0
`define LIONC_B_NMI_GMASK  7
`define LIONC_STATUS_RESET 8'h00
`define LIONC_ALL_ONES     8'hFF
// refresh toggle half period, 15 us at 10 MHz
`define LIONC_REFRESH_NS   15000
`define LIONC_CLK_NS       100
`define LIONC_REFRESH_CYC  (`LIONC_REFRESH_NS / `LIONC_CLK_NS)
// target codes
`define LIONC_T_NONE       4'h0
`define LIONC_T_PIC1       4'h1
`define LIONC_T_PIC2       4'h2
`define LIONC_T_PIT        4'h3
`define LIONC_T_NMI        4'h4
`define LIONC_T_RTC        4'h5
`define LIONC_T_PM         4'h6
`define LIONC_T_INTERNAL   4'h7
`define LIONC_T_ATA        4'h8
`define LIONC_T_CFG        4'h9
`define LIONC_T_SMB        4'hA
`define LIONC_T_GPIO       4'hB
`define LIONC_T_USB1       4'hC
`define LIONC_T_USB2       4'hD
`define LIONC_T_USB3       4'hE
`define LIONC_T_NMI_RTC    4'hF
`endif

// ===== core/lionc_range_match.v
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// one relocatable window: naturally aligned, size 2**SZ bytes
// ---------------------------------------------------------------
module lionc_range_match #(
   parameter SZ = 4
) (
   input  wire [15:0] addr_in,
   input  wire [15:0] base_in,
   input  wire        enable_in,
   output wire        hit_out
);
   wire [15:0] mask = 16'hFFFF << SZ;
   assign hit_out = enable_in & ((addr_in & mask) == (base_in & mask));
endmodule // lionc_range_match
`default_nettype wire

// ===== verification/lionc_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "lionc_map.vh"
// ------
// port checks
// ------
module lionc_decoder_checker (
   input wire logic        clock_in,
   input wire logic        rstn_in,
   input wire logic        io_valid_in,
   input wire logic        io_write_in,
   input wire logic [15:0] io_addr_in,
   input wire logic [7:0]  io_wdata_in,
   input wire logic        port_alias_enable_in,
   input wire logic        counter2_out_in,
   input wire logic [7:0]  io_rdata_out,
   input wire logic [3:0]  tgt_sel_out,
   input wire logic        aborted_out,
   input wire logic        lpc_fwd_out,
   input wire logic        speaker_out,
   input wire logic [6:0]  rtc_index_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   wire logic rq = io_valid_in && !io_write_in;
   wire logic wq = io_valid_in && io_write_in;
   abort_ones_a: assert property (aborted_out && !$past(io_write_in)
      |-> io_rdata_out == 8'hFF) else $error("aborted read not all ones");
   pic1_route_a: assert property (io_valid_in && io_addr_in[15:5] == 11'h001
      && !io_addr_in[1] |=> tgt_sel_out == `LIONC_T_PIC1) else $error("master irq decode");
   pm_route_a: assert property (io_valid_in && io_addr_in[15:1] == 15'h0059
      |=> tgt_sel_out == `LIONC_T_PM) else $error("power port decode");
   alias_off_a: assert property (io_valid_in && !port_alias_enable_in
      && io_addr_in inside {16'h0063, 16'h0065, 16'h0067} |=> aborted_out)
      else $error("alias decoded while off");
   index_read_a: assert property (rq && io_addr_in == 16'h0070 |=> aborted_out)
      else $error("index port read not aborted");
   lpc_copy_a: assert property (io_valid_in && io_addr_in == 16'h0088
      |=> lpc_fwd_out == $past(io_write_in)) else $error("lpc forward wrong");
   speaker_gate_a: assert property (speaker_out |-> $past(counter2_out_in))
      else $error("speaker high without counter");
   index_store_a: assert property (wq && io_addr_in == 16'h0070
      |=> rtc_index_out == $past(io_wdata_in[6:0])) else $error("index not stored");
   cover property (aborted_out && !$past(io_write_in));
   cover property (lpc_fwd_out);
   cover property (speaker_out);
endmodule // lionc_decoder_checker
bind lionc_decoder lionc_decoder_checker lionc_decoder_checker_i (.*);
`default_nettype wire

// ===== verification/lionc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// processor side and target read data
// ------
module lionc_cpu_model (
   input  wire logic        clock_in,
   output var  logic        io_valid_out,
   output var  logic        io_write_out,
   output var  logic [15:0] io_addr_out,
   output var  logic [7:0]  io_wdata_out,
   output var  logic [7:0]  tgt_rdata_out
);
   initial
   begin
      io_valid_out = 1'b0;
      io_write_out = 1'b0;
      io_addr_out = 16'hFFFF;
      io_wdata_out = 8'hFF;
      tgt_rdata_out = 8'hFF;
   end
   // one cycle per request; released lines go inverted so stale values never match
   task automatic run(input logic wr, input logic [15:0] ad, input logic [7:0] dt, tr);
      @(posedge clock_in);
      io_valid_out <= 1'b1;
      io_write_out <= wr;
      io_addr_out <= ad;
      io_wdata_out <= dt;
      tgt_rdata_out <= tr;
      @(posedge clock_in);
      io_valid_out <= 1'b0;
      io_addr_out <= ~ad;
      io_wdata_out <= ~dt;
      tgt_rdata_out <= ~tr;
      #1;
   endtask
endmodule // lionc_cpu_model
`default_nettype wire

// ===== verification/lionc_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "lionc_map.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin miscompares++; \
   $display("BAD %s exp %0h got %0h", n, e, s); end end
module lionc_decoder_test;
   logic        clock_in = 0, rstn_in = 0, ae = 0, pe = 0, serr = 0, ioc = 0, c2 = 0;
   logic [6:0]  ren = 0;
   logic [15:0] bs [7] = '{default: 16'h0000};
   logic [15:0] ra, cl [12] = '{16'h0010, 16'h003D, 16'h003E, 16'h0043, 16'h0063, 16'h0070,
      16'h0072, 16'h0088, 16'h0089, 16'h00B3, 16'h0177, 16'h0CFF};
   logic [3:0]  cd [7] = '{`LIONC_T_PM, `LIONC_T_ATA, `LIONC_T_SMB, `LIONC_T_GPIO,
      `LIONC_T_USB1, `LIONC_T_USB2, `LIONC_T_USB3};
   int          sz [7] = '{64, 16, 32, 64, 32, 32, 32};
   wire logic   v, w, done, tv, tw, lpc, ab, nmi, spk, gate;
   wire logic [15:0] a, ta;
   wire logic [7:0]  d, td, rd, twd;
   wire logic [3:0]  sel;
   wire logic [6:0]  rtc_index;
   logic [7:0]  st;
   int          miscompares = 0, total_checks = 0;
   lionc_cpu_model lionc_cpu_model_i (.clock_in(clock_in), .io_valid_out(v), .io_write_out(w),
      .io_addr_out(a), .io_wdata_out(d), .tgt_rdata_out(td));
   lionc_decoder #(.REFRESH_CYC(4)) lionc_decoder_i (.clock_in(clock_in), .rstn_in(rstn_in),
      .io_valid_in(v), .io_write_in(w), .io_addr_in(a), .io_wdata_in(d), .tgt_rdata_in(td),
      .port_alias_enable_in(ae), .rtc_hi_pair_enable_in(pe), .acpi_base_in(bs[0]),
      .bmide_base_in(bs[1]), .smb_base_in(bs[2]), .gpio_base_in(bs[3]), .usb1_base_in(bs[4]),
      .usb2_base_in(bs[5]), .usb3_base_in(bs[6]), .range_enable_in(ren),
      .system_error_in(serr), .io_check_error_in(ioc), .counter2_out_in(c2),
      .io_done_out(done), .io_rdata_out(rd), .tgt_sel_out(sel), .tgt_valid_out(tv),
      .tgt_write_out(tw), .tgt_addr_out(ta), .tgt_wdata_out(twd), .lpc_fwd_out(lpc),
      .aborted_out(ab), .nmi_out(nmi), .speaker_out(spk), .counter2_gate_out(gate),
      .rtc_index_out(rtc_index));
   initial
   begin
      forever #50 clock_in = ~clock_in;
   end
   // ------
   // expected fixed decode: {lpc copy, target}
   // ------
   function automatic logic [4:0] dec(input logic wr, input logic [15:0] x);
      logic [3:0] s;
      s = `LIONC_T_NONE;
      if ((x[15:5] == 11'h001 || x[15:5] == 11'h005) && !x[1])
         s = x[7] ? `LIONC_T_PIC2 : `LIONC_T_PIC1;
      if (x[15:1] == 15'h0059)
         s = `LIONC_T_PM;
      if ((x[15:4] == 12'h004 || x[15:4] == 12'h005) && x[3:2] == 2'b00 && (wr || x[1:0] != 3))
         s = `LIONC_T_PIT;
      if (x == 16'h0061 || (ae && (x == 16'h0063 || x == 16'h0065 || x == 16'h0067)))
         s = `LIONC_T_NMI;
      if (x == 16'h0070 && wr)
         s = `LIONC_T_NMI_RTC;
      if (x[15:3] == 13'h000E && x[2:0] != 0 && (pe || x[2:1] != 2'b01))
         s = (wr && !x[0]) ? `LIONC_T_NMI_RTC : `LIONC_T_RTC;
      if (((x[15:2] == 14'h0021 || x[15:2] == 14'h0023) && x[1:0] != 3) || x == 16'h0088)
         s = `LIONC_T_INTERNAL;
      if (x[15:3] == 13'h002E || x[15:3] == 13'h003E || x == 16'h0376 || x == 16'h03F6)
         s = `LIONC_T_ATA;
      if (x[15:3] == 13'h019F)
         s = `LIONC_T_CFG;
      return {wr && s == `LIONC_T_INTERNAL, s};
   endfunction
   task automatic io(input logic wr, input logic [15:0] x, input logic [7:0] dt,
                     input logic [4:0] e);
      logic [7:0] t;
      t = 8'($urandom);
      lionc_cpu_model_i.run(wr, x, dt, t);
      `CHK("done", 1'b1, done)
      `CHK("target", e[3:0], sel)
      `CHK("abort", e[3:0] == `LIONC_T_NONE, ab)
      `CHK("lpc", e[4], lpc)
      `CHK("forward", e[3:0] != `LIONC_T_NONE, tv)
      `CHK("tgt write", wr, tw)
      `CHK("tgt addr", x, ta)
      `CHK("tgt data", dt, twd)
      if (!wr && e[3:0] == `LIONC_T_NONE) `CHK("ones", 8'hFF, rd)
      if (!wr && e[3:0] == `LIONC_T_RTC) `CHK("rdata", t, rd)
   endtask
   task automatic rs();
      io(1'b0, 16'h0061, 8'h00, dec(1'b0, 16'h0061));
   endtask
   task automatic pulse(input logic k);
      @(posedge clock_in);
      if (k)
         ioc <= 1'b1;
      else
         serr <= 1'b1;
      @(posedge clock_in);
      ioc <= 1'b0;
      serr <= 1'b0;
      @(posedge clock_in);
      #1;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #2000000;
      miscompares++;
      end_of_test();
   end
   initial
   begin
      void'($urandom(88145));
      repeat (5) @(posedge clock_in);
      `CHK("reset", 5'h00, {done, ab, nmi, spk, gate})
      rstn_in <= 1'b1;
      rs();
      `CHK("mask reset", 4'h0, rd[3:0])
      for (int p = 0; p < 4; p++)
      begin
         @(posedge clock_in);
         ae <= p[0];
         pe <= p[1];
         @(posedge clock_in);
         foreach (cl[i]) for (int k = 0; k < 2; k++) io(k[0], cl[i], 8'h00, dec(k[0], cl[i]));
      end
      repeat (300)
      begin
         ra = 16'($urandom % 1024) | ($urandom % 4 == 0 ? 16'h0C00 : 16'h0000);
         st = (ra[15:4] == 6 || ra[15:4] == 7) ? 8'h00 : 8'($urandom);
         io(ra[0] ^ ra[9], ra, st, dec(ra[0] ^ ra[9], ra));
      end
      $display("decode test done");
      for (int i = 0; i < 7; i++)
      begin
         ra = i == 0 ? 16'hFFC0 : (16'($urandom) | 16'h4000) & ~16'(sz[i] - 1);
         @(posedge clock_in);
         bs[i] <= ra;
         ren <= 7'(1 << i);
         @(posedge clock_in);
         io(1'b0, ra + 16'(sz[i] - 1), 8'h00, {1'b0, cd[i]});
         io(1'b1, ra, 8'h5A, {1'b0, cd[i]});
         io(1'b0, ra + 16'(sz[i]), 8'h00, dec(1'b0, ra + 16'(sz[i])));
      end
      $display("relocation test done");
      for (int k = 0; k < 2; k++)
      begin
         pulse(k[0]);
         `CHK("nmi", 1'b1, nmi)
         rs();
         `CHK("flag", 1'b1, rd[7 - k])
         io(1'b1, 16'h0061, k ? 8'h08 : 8'h04, dec(1'b1, 16'h0061));
         pulse(k[0]);
         rs();
         `CHK("masked", 2'b00, rd[7:6])
         `CHK("nmi off", 1'b0, nmi)
         io(1'b1, 16'h0061, 8'h00, dec(1'b1, 16'h0061));
      end
      io(1'b1, 16'h0070, 8'hA5, dec(1'b1, 16'h0070));
      `CHK("index", 7'h25, rtc_index)
      pulse(1'b0);
      `CHK("global", 1'b0, nmi)
      io(1'b1, 16'h0070, 8'h00, dec(1'b1, 16'h0070));
      @(posedge clock_in);
      #1;
      `CHK("unmask", 1'b1, nmi)
      $display("nmi test done");
      for (int q = 0; q < 4; q++)
      begin
         io(1'b1, 16'h0061, 8'(q), dec(1'b1, 16'h0061));
         `CHK("gate", q[0], gate)
         @(posedge clock_in);
         c2 <= 1'b1;
         repeat (2) @(posedge clock_in);
         #1;
         `CHK("speaker", q[1], spk)
         rs();
         `CHK("counter2", 1'b1, rd[5])
         @(posedge clock_in);
         c2 <= 1'b0;
      end
      rs();
      st = rd;
      repeat (2) rs();
      `CHK("refresh", ~st[4], rd[4])
      repeat (2) rs();
      `CHK("refresh", st[4], rd[4])
      $display("control test done");
      end_of_test();
   end
endmodule // lionc_decoder_test
`default_nettype wire
